/* File: flt_top.sv */
// Fast lock timer, charge pump boost, loop switches and frequency readback
// Functional notes
// RQ1 - Host readback order: R0 write, load high, trigger, read, trigger, R4, read, trigger.
// RQ2 - Nonzero fast lock mode: every frequency write starts the wide-bandwidth state.
// RQ3 - Wide-bandwidth state lasts first divider times second divider PFD periods.
// RQ4 - First divider is the 12-bit field at bits 14..3 of register two.
// RQ5 - Second divider is the 12-bit field at bits 18..7 of register four.
// RQ6 - Fast lock never applies while a frequency ramp is active.
// RQ7 - Host finishes power-up initialisation before first enabling fast lock.
// RQ8 - Charge pump current is sixteen times normal while wide-bandwidth is active.
// RQ9 - Divider mode: ground switch shorted, pump switch tied to pump during fast lock.
// RQ10 - Interpolator is a third-order sigma-delta, fixed 25-bit modulus, per PFD cycle.
// RQ11 - Readback starts on trigger pin rising edge with interrupt mode and ramp active.
// RQ12 - Readback shifts 37 bits: 12 integer bits then 25 fractional bits.
// RQ13 - Frequency write during fast lock restarts the timer with current dividers.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module flt_top
(
    // Clock, reset and clock enable (clock is the PFD clock)
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_resetn,
    input  wire logic                        i_ce,
    // Register port
    input  wire flt_pkg::flt_bus_req_t       i_bus,
    output logic      [flt_pkg::DATA_W-1:0]  o_rdata,
    // Serial interface pins
    input  wire logic                        i_load_enable_pin,
    input  wire logic                        i_sclk_pin,
    input  wire logic                        i_trigger_pin,
    output logic                             o_multiplexed_output_pin,
    // Loop control
    output flt_pkg::flt_loop_t               o_loop,
    output logic      [flt_pkg::NDIV_W-1:0]  o_ndiv
);
    import flt_pkg::*;

    typedef struct packed {
        flt_cfg_t             cfg;
        logic                 fl_active;
        logic [TIMER_W-1:0]   timer;
        logic [TIMER_W-1:0]   target;
        logic [DATA_W-1:0]    rdata;
        logic [2:0]           trig_s;
        logic [2:0]           sclk_s;
        logic [1:0]           load_s;
        logic [RB_W-1:0]      shreg;
        logic [RBCNT_W-1:0]   shcnt;
        logic                 mux;
        flt_loop_t            loop;
    } flt_state_t;

    flt_state_t st_r;
    flt_state_t st_nxt;

    // Rising edge on the second stage of a two-flop synchroniser
    function automatic logic rise(input logic [2:0] s);
        rise = s[1] & ~s[2];
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic wr_freq;
        logic [TIMER_W-1:0] prod;
        logic fl_allowed;
        wr_freq = 1'b0;
        prod = '0;
        fl_allowed = 1'b0;
        st_nxt = st_r;

        // Pin synchronisers; only the second stage onward feeds logic
        st_nxt.trig_s = {st_r.trig_s[1:0], i_trigger_pin};
        st_nxt.sclk_s = {st_r.sclk_s[1:0], i_sclk_pin};
        st_nxt.load_s = {st_r.load_s[0], i_load_enable_pin};

        // Register writes
        if (i_bus.wr)
        begin
            unique case (i_bus.addr)
                ADDR_FREQ:
                begin
                    st_nxt.cfg.int_val = i_bus.wdata[INT_LSB +: INT_W];
                    wr_freq = 1'b1;
                end
                ADDR_FRACTIONAL_DIVIDER_VALUE: st_nxt.cfg.fractional_divider_value = i_bus.wdata[FRACTIONAL_DIVIDER_VALUE_LSB +: FRACTIONAL_DIVIDER_VALUE_W];
                ADDR_DIV1: st_nxt.cfg.div1 = i_bus.wdata[DIV1_LSB +: DIV_W];      // RQ4
                ADDR_DIV2:
                begin
                    st_nxt.cfg.div2    = i_bus.wdata[DIV2_LSB +: DIV_W];          // RQ5
                    st_nxt.cfg.flm     = i_bus.wdata[FLM_LSB +: 2];
                    st_nxt.cfg.cp_code = i_bus.wdata[CP_LSB +: CP_W];
                end
                ADDR_RAMP:
                begin
                    st_nxt.cfg.ramp     = i_bus.wdata[RAMP_BIT];
                    st_nxt.cfg.irq_mode = i_bus.wdata[IRQ_LSB +: 2];
                end
                default: ;
            endcase
        end

        // --------------------------------------------------------------
        // Fast lock timer
        // --------------------------------------------------------------
        // Dividers are taken as they stand after this cycle's write
        prod = TIMER_W'(st_nxt.cfg.div1 * st_nxt.cfg.div2);                       // RQ3
        fl_allowed = (st_nxt.cfg.flm != FLM_OFF) && !st_nxt.cfg.ramp;            // RQ6
        if (st_r.fl_active)
        begin
            if (st_r.timer == st_r.target - TIMER_W'(1))
                st_nxt.fl_active = 1'b0;                                        // RQ3
            else
                st_nxt.timer = st_r.timer + TIMER_W'(1);
        end
        if (!fl_allowed)
            st_nxt.fl_active = 1'b0;                                            // RQ6
        // A zero product means no wide-bandwidth time at all
        if (wr_freq && fl_allowed && prod != '0)
        begin
            st_nxt.fl_active = 1'b1;                                            // RQ2
            st_nxt.timer     = '0;                                              // RQ13
            st_nxt.target    = prod;                                            // RQ13
        end

        // Loop drive follows the timer state of the next cycle
        st_nxt.loop.cp_current = CPO_W'(st_nxt.cfg.cp_code)
                               * (st_nxt.fl_active ? CP_BOOST : CP_UNITY);      // RQ8
        st_nxt.loop.ground = st_nxt.fl_active && st_nxt.cfg.flm == FLM_DIV;     // RQ9
        st_nxt.loop.pump   = st_nxt.fl_active && st_nxt.cfg.flm == FLM_DIV;     // RQ9

        // --------------------------------------------------------------
        // Frequency readback
        // --------------------------------------------------------------
        if (rise(st_r.trig_s) && st_r.cfg.ramp && st_r.cfg.irq_mode != IRQ_OFF)  // RQ11
        begin
            // Integer first, MSB first; a new trigger aborts a readback in flight
            st_nxt.mux   = st_r.cfg.int_val[INT_W-1];                           // RQ12
            st_nxt.shreg = {st_r.cfg.int_val, st_r.cfg.fractional_divider_value} << 1;              // RQ12
            st_nxt.shcnt = RB_BITS - RBCNT_W'(1);                               // RQ12
        end
        else if (rise(st_r.sclk_s) && st_r.load_s[1])
        begin
            if (st_r.shcnt != '0)
            begin
                st_nxt.mux   = st_r.shreg[RB_W-1];                              // RQ12
                st_nxt.shreg = st_r.shreg << 1;
                st_nxt.shcnt = st_r.shcnt - RBCNT_W'(1);
            end
            else
                st_nxt.mux = 1'b0;
        end

        // --------------------------------------------------------------
        // Register reads: data valid for one cycle only
        // --------------------------------------------------------------
        st_nxt.rdata = '0;
        if (i_bus.rd)
        begin
            unique case (i_bus.addr)
                ADDR_FREQ:  st_nxt.rdata[INT_LSB +: INT_W]   = st_r.cfg.int_val;
                ADDR_FRACTIONAL_DIVIDER_VALUE:  st_nxt.rdata[FRACTIONAL_DIVIDER_VALUE_LSB +: FRACTIONAL_DIVIDER_VALUE_W] = st_r.cfg.fractional_divider_value;
                ADDR_DIV1:  st_nxt.rdata[DIV1_LSB +: DIV_W]  = st_r.cfg.div1;
                ADDR_DIV2:
                begin
                    st_nxt.rdata[DIV2_LSB +: DIV_W] = st_r.cfg.div2;
                    st_nxt.rdata[FLM_LSB +: 2]      = st_r.cfg.flm;
                    st_nxt.rdata[CP_LSB +: CP_W]    = st_r.cfg.cp_code;
                end
                ADDR_RAMP:
                begin
                    st_nxt.rdata[RAMP_BIT]    = st_r.cfg.ramp;
                    st_nxt.rdata[IRQ_LSB +: 2] = st_r.cfg.irq_mode;
                end
                ADDR_STAT:
                begin
                    st_nxt.rdata[ST_FL_BIT] = st_r.fl_active;
                    st_nxt.rdata[ST_RB_BIT] = st_r.shcnt != '0;
                end
                ADDR_TIMER: st_nxt.rdata[TIMER_W-1:0] = st_r.timer;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            st_r <= '0;
        else if (i_ce)
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // Interpolator and outputs
    // ------------------------------------------------------------------
    flt_sdm u_sdm
    (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_int_val (st_r.cfg.int_val),
        .i_fractional_divider_value    (st_r.cfg.fractional_divider_value),
        .o_ndiv    (o_ndiv)
    );

    assign o_rdata                  = st_r.rdata;
    assign o_multiplexed_output_pin = st_r.mux;
    assign o_loop                   = st_r.loop;

endmodule

/* File: flt_pkg.sv */
// Shared constants and carrier types for the fast lock timer and readback block
package flt_pkg;

    // ------------------------------------------------------------------
    // Bus geometry and register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W     = 8;
    localparam int         DATA_W     = 32;
    localparam logic [7:0] ADDR_FREQ  = 8'h00;
    localparam logic [7:0] ADDR_FRACTIONAL_DIVIDER_VALUE  = 8'h04;
    localparam logic [7:0] ADDR_DIV1  = 8'h08;
    localparam logic [7:0] ADDR_DIV2  = 8'h0c;
    localparam logic [7:0] ADDR_RAMP  = 8'h10;
    localparam logic [7:0] ADDR_STAT  = 8'h14;
    localparam logic [7:0] ADDR_TIMER = 8'h18;

    // ------------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------------
    localparam int INT_W      = 12;
    localparam int FRACTIONAL_DIVIDER_VALUE_W     = 25;
    localparam int RB_W       = INT_W + FRACTIONAL_DIVIDER_VALUE_W;
    localparam int DIV_W      = 12;
    localparam int TIMER_W    = 2 * DIV_W;
    localparam int CP_W       = 4;
    localparam int CPO_W      = 8;
    localparam int NDIV_W     = 13;
    localparam int RBCNT_W    = 6;
    localparam int INT_LSB    = 0;
    localparam int FRACTIONAL_DIVIDER_VALUE_LSB   = 0;
    localparam int DIV1_LSB   = 3;
    localparam int DIV2_LSB   = 7;
    localparam int FLM_LSB    = 19;
    localparam int CP_LSB     = 0;
    localparam int RAMP_BIT   = 0;
    localparam int IRQ_LSB    = 1;
    localparam int ST_FL_BIT  = 0;
    localparam int ST_RB_BIT  = 1;

    // ------------------------------------------------------------------
    // Codes, pump multipliers and readback length
    // ------------------------------------------------------------------
    localparam logic [1:0]        FLM_OFF    = 2'h0;
    localparam logic [1:0]        FLM_DIV    = 2'h1;
    localparam logic [1:0]        IRQ_OFF    = 2'h0;
    localparam logic [CPO_W-1:0]  CP_BOOST   = 8'h10;
    localparam logic [CPO_W-1:0]  CP_UNITY   = 8'h01;
    localparam logic [RBCNT_W-1:0] RB_BITS   = 6'h25;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } flt_bus_req_t;

    typedef struct packed {
        logic [INT_W-1:0]  int_val;
        logic [FRACTIONAL_DIVIDER_VALUE_W-1:0] fractional_divider_value;
        logic [DIV_W-1:0]  div1;
        logic [DIV_W-1:0]  div2;
        logic [1:0]        flm;
        logic [CP_W-1:0]   cp_code;
        logic              ramp;
        logic [1:0]        irq_mode;
    } flt_cfg_t;

    typedef struct packed {
        logic             ground;
        logic             pump;
        logic [CPO_W-1:0] cp_current;
    } flt_loop_t;

endpackage

/* File: flt_sdm.sv */
// Third-order sigma-delta fractional interpolator with fixed 2^25 modulus
`timescale 1ns/10ps
module flt_sdm
(
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_resetn,
    input  wire logic                       i_ce,
    // Divider word
    input  wire logic [flt_pkg::INT_W-1:0]  i_int_val,
    input  wire logic [flt_pkg::FRACTIONAL_DIVIDER_VALUE_W-1:0] i_fractional_divider_value,
    // Instantaneous divide ratio
    output logic      [flt_pkg::NDIV_W-1:0] o_ndiv
);
    import flt_pkg::*;

    typedef struct packed {
        logic [FRACTIONAL_DIVIDER_VALUE_W-1:0] acc1;
        logic [FRACTIONAL_DIVIDER_VALUE_W-1:0] acc2;
        logic [FRACTIONAL_DIVIDER_VALUE_W-1:0] acc3;
        logic              c2_d;
        logic              c3_d;
        logic              c3_dd;
        logic [NDIV_W-1:0] ndiv;
    } flt_sdm_t;

    flt_sdm_t st_r;
    flt_sdm_t st_nxt;

    // ------------------------------------------------------------------
    // Cascade of three first-order stages, noise cancelled at the output
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [FRACTIONAL_DIVIDER_VALUE_W:0] s1;
        logic [FRACTIONAL_DIVIDER_VALUE_W:0] s2;
        logic [FRACTIONAL_DIVIDER_VALUE_W:0] s3;
        logic [4:0]      d;
        s1 = '0;
        s2 = '0;
        s3 = '0;
        d = '0;
        st_nxt = st_r;
        // One update per PFD cycle; the modulus is the full accumulator range
        s1 = {1'b0, st_r.acc1} + {1'b0, i_fractional_divider_value};                          // RQ10
        s2 = {1'b0, st_r.acc2} + {1'b0, s1[FRACTIONAL_DIVIDER_VALUE_W-1:0]};
        s3 = {1'b0, st_r.acc3} + {1'b0, s2[FRACTIONAL_DIVIDER_VALUE_W-1:0]};
        d  = 5'(s1[FRACTIONAL_DIVIDER_VALUE_W]) + 5'(s2[FRACTIONAL_DIVIDER_VALUE_W]) + 5'(s3[FRACTIONAL_DIVIDER_VALUE_W]) + 5'(st_r.c3_dd)
           - 5'(st_r.c2_d) - 5'({st_r.c3_d, 1'b0});
        st_nxt.acc1  = s1[FRACTIONAL_DIVIDER_VALUE_W-1:0];
        st_nxt.acc2  = s2[FRACTIONAL_DIVIDER_VALUE_W-1:0];
        st_nxt.acc3  = s3[FRACTIONAL_DIVIDER_VALUE_W-1:0];
        st_nxt.c2_d  = s2[FRACTIONAL_DIVIDER_VALUE_W];
        st_nxt.c3_d  = s3[FRACTIONAL_DIVIDER_VALUE_W];
        st_nxt.c3_dd = st_r.c3_d;
        st_nxt.ndiv  = NDIV_W'({1'b0, i_int_val}) + {{(NDIV_W-5){d[4]}}, d};
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            st_r <= '0;
        else if (i_ce)
            st_r <= st_nxt;
    end

    assign o_ndiv = st_r.ndiv;

endmodule

/* File: flt_host_model.sv */
// Host controller model driving the serial readback pins
`timescale 1ns/10ps
module flt_host_model
(
    // Clock
    input  wire logic i_clk_sys,
    // Serial pins
    input  wire logic i_mux,
    output logic      o_load_en,
    output logic      o_sclk,
    output logic      o_trig
);
    initial {o_load_en, o_sclk, o_trig} = '0;

    task automatic set_le(input logic v);
        o_load_en <= v;
        @(posedge i_clk_sys);
    endtask

    // Pins are held 4 cycles so the device synchronisers always see each edge;
    // the serial clock stands still between frames
    task automatic read_word(output logic [36:0] w, output logic z);
        o_trig <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        o_trig <= 1'b0;
        for (int i = 36; i >= -1; i--)
        begin
            if (i < 36)
            begin
                o_sclk <= 1'b1;
                repeat (4) @(posedge i_clk_sys);
                o_sclk <= 1'b0;
            end
            repeat (6) @(posedge i_clk_sys);
            if (i < 0) z = i_mux;
            else w[i] = i_mux;
        end
    endtask
endmodule

/* File: flt_checker.sv */
// Concurrent checks on the fast lock timer and readback ports
`timescale 1ns/10ps
module flt_checker
(
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_resetn,
    input  wire logic                       i_ce,
    // Register port
    input  wire flt_pkg::flt_bus_req_t      i_bus,
    input  wire logic [flt_pkg::DATA_W-1:0] o_rdata,
    // Serial pins
    input  wire logic                       i_load_enable_pin,
    input  wire logic                       i_sclk_pin,
    input  wire logic                       i_trigger_pin,
    input  wire logic                       o_multiplexed_output_pin,
    // Loop control
    input  wire flt_pkg::flt_loop_t         o_loop,
    input  wire logic [flt_pkg::NDIV_W-1:0] o_ndiv
);
    import flt_pkg::*;
    // ------------------------------------------------------------------
    // Shadow of the configuration and of the wide-bandwidth timer
    // ------------------------------------------------------------------
    logic [11:0] d1_r, d2_r, int_r;
    logic [1:0]  md_r, irq_r;
    logic [3:0]  cp_r;
    logic        rp_r;
    logic [23:0] cnt_r;
    wire         wr_f = i_ce && i_bus.wr && i_bus.addr == ADDR_FREQ;
    wire         wr_c = i_ce && i_bus.wr && i_bus.addr == ADDR_DIV2;
    wire         wr_r = i_ce && i_bus.wr && i_bus.addr == ADDR_RAMP;
    wire         act = cnt_r != 24'h0;
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            {d1_r, d2_r, int_r, md_r, irq_r, cp_r, rp_r, cnt_r} <= '0;
        else
        begin
            if (i_ce && i_bus.wr && i_bus.addr == ADDR_DIV1)
                d1_r <= i_bus.wdata[14:3];
            if (wr_c)
                {md_r, d2_r} <= i_bus.wdata[20:7];
            if (wr_c)
                cp_r <= i_bus.wdata[3:0];
            if (wr_f)
                int_r <= i_bus.wdata[11:0];
            if (wr_r)
                {irq_r, rp_r} <= i_bus.wdata[2:0];
            if (wr_f && md_r != FLM_OFF && !rp_r)
                cnt_r <= d1_r * d2_r;
            else if ((wr_c && i_bus.wdata[20:19] == FLM_OFF) || (wr_r && i_bus.wdata[0]))
                cnt_r <= '0;
            else if (act && i_ce)
                cnt_r <= cnt_r - 24'h1;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // ------------------------------------------------------------------
    // Assertions and cover properties
    // ------------------------------------------------------------------
    a_fl_start: assert property (
        wr_f && md_r != FLM_OFF && !rp_r && d1_r != 0 && d2_r != 0
        |=> o_loop.cp_current == {cp_r, 4'h0}) else $error("fast lock did not start");
    a_boost_level: assert property (!$past(wr_c) |->
        o_loop.cp_current == (act ? {cp_r, 4'h0} : {4'h0, cp_r})) else $error("pump level wrong");
    a_switch_mode: assert property (!$past(wr_c) |-> o_loop.pump == o_loop.ground &&
        o_loop.ground == (act && md_r == FLM_DIV)) else $error("loop switches wrong");
    a_ramp_blocks: assert property (rp_r && $past(rp_r) && !$past(wr_c) |->
        !o_loop.ground && o_loop.cp_current == {4'h0, cp_r}) else $error("boost during ramp");
    a_fl_end: assert property (cnt_r == 24'h1 && !wr_f && !wr_c && i_ce |=>
        o_loop.cp_current == {4'h0, cp_r} && !o_loop.ground) else $error("boost overran");
    a_rb_start: assert property ($rose(i_trigger_pin) && rp_r && irq_r != 0 && int_r[11]
        |-> ##[2:6] o_multiplexed_output_pin) else $error("readback did not start");
    a_rb_quiet: assert property ((!i_load_enable_pin && !i_trigger_pin) [*6]
        |-> $stable(o_multiplexed_output_pin)) else $error("readback moved while idle");
    a_ndiv_range: assert property ((int_r > 12'h3 && $stable(int_r)) [*4] |->
        o_ndiv + 13'h3 >= {1'b0, int_r} && o_ndiv <= {1'b0, int_r} + 13'h4)
        else $error("divide ratio out of range");
    c_fl_done: cover property (cnt_r == 24'h1);
    c_restart: cover property (wr_f && act);
    c_readback: cover property ($rose(i_trigger_pin) && rp_r);
endmodule

bind flt_top flt_checker u_chk (.i_clk_sys, .i_resetn, .i_ce, .i_bus, .o_rdata,
    .i_load_enable_pin, .i_sclk_pin, .i_trigger_pin, .o_multiplexed_output_pin,
    .o_loop, .o_ndiv);

/* File: flt_top_test.sv */
// Self-checking testbench for the fast lock timer and readback block
`timescale 1ns/10ps
module flt_top_test;
    import flt_pkg::*;
    logic              i_clk_sys = 1'b0;
    logic              i_resetn = 1'b0;
    flt_bus_req_t      bus = '0;
    logic [DATA_W-1:0] rdata;
    logic              load_en, sclk, trig, mux, z;
    logic              ce = 1'b1;
    flt_loop_t         loop;
    logic [NDIV_W-1:0] ndiv;
    logic [36:0]       w;
    int                fail_count = 0;
    int                checked = 0;
    int                cyc = 0;
    int                d1 [7] = '{2, 1, 0, 12, 2, 2, 2};
    int                d2 [7] = '{3, 1, 5, 10, 3, 3, 3};
    int                md [7] = '{1, 1, 1, 1, 0, 2, 3};

    always #20 i_clk_sys = ~i_clk_sys;

    flt_top u_dut (.i_clk_sys, .i_resetn, .i_ce(ce), .i_bus(bus), .o_rdata(rdata),
        .i_load_enable_pin(load_en), .i_sclk_pin(sclk), .i_trigger_pin(trig),
        .o_multiplexed_output_pin(mux), .o_loop(loop), .o_ndiv(ndiv));
    flt_host_model u_host (.i_clk_sys, .i_mux(mux), .o_load_en(load_en), .o_sclk(sclk),
        .o_trig(trig));

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // The strobe stays up after a write so that the next call never drives it
    // twice in one step; idle lowers it once a burst is over
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk_sys);
    endtask

    task automatic idle();
        bus <= '0;
        @(posedge i_clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk_sys);
        bus.rd <= 1'b0;
        @(posedge i_clk_sys);
        check(rdata, e);
    endtask

    // Counts boosted cycles after a write, with the pump code fixed at 1
    task automatic fl_len(input logic [23:0] e, input logic sw);
        int n;
        n = 0;
        idle();
        if (e != 0) check(loop.ground, sw);
        while (loop.cp_current === 8'h10 && n < 5000)
        begin
            n++;
            @(posedge i_clk_sys);
        end
        check(n, e);
        check(loop.cp_current, 8'h01);
    endtask

    always @(posedge i_clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        @(posedge i_clk_sys);
        check(loop, '0);
        rd(8'h1c, 32'h0);
        wr(ADDR_FREQ, 32'h855);
        wr(ADDR_FRACTIONAL_DIVIDER_VALUE, 32'h1abcdef);
        rd(ADDR_FRACTIONAL_DIVIDER_VALUE, 32'h01abcdef);
        for (int i = 0; i < 7; i++)
        begin
            wr(ADDR_DIV1, 32'(d1[i]) << 3);
            wr(ADDR_DIV2, (32'(d2[i]) << 7) | (32'(md[i]) << 19) | 32'h1);
            wr(ADDR_FREQ, 32'h855);
            fl_len(24'(md[i] == 0 ? 0 : d1[i] * d2[i]), md[i] == 1);
        end
        wr(ADDR_DIV2, 32'h00080181);
        wr(ADDR_FREQ, 32'h855);
        wr(ADDR_FREQ, 32'h855);
        fl_len(24'd6, 1'b1);
        rd(ADDR_DIV2, 32'h00080181);
        // Four frozen cycles must not eat into the boost time
        wr(ADDR_FREQ, 32'h855);
        ce <= 1'b0;
        idle();
        repeat (3) @(posedge i_clk_sys);
        ce <= 1'b1;
        fl_len(24'd6, 1'b1);
        wr(ADDR_FREQ, 32'h855);
        wr(ADDR_RAMP, 32'h3);
        fl_len(24'd0, 1'b0);
        wr(ADDR_FREQ, 32'h855);
        fl_len(24'd0, 1'b0);
        u_host.set_le(1'b1);
        u_host.read_word(w, z);
        check(w, {12'h855, 25'h1abcdef});
        check(z, 1'b0);
        wr(ADDR_DIV2, 32'h00080181);
        idle();
        u_host.read_word(w, z);
        check(w, {12'h855, 25'h1abcdef});
        wr(ADDR_RAMP, 32'h1);
        idle();
        u_host.read_word(w, z);
        check(w, 37'h0);
        wr(ADDR_RAMP, 32'h3);
        rd(ADDR_RAMP, 32'h00000003);
        u_host.set_le(1'b0);
        u_host.read_word(w, z);
        check(w, {37{1'b1}});
        rd(ADDR_STAT, 32'h00000002);
        check(ndiv >= 13'h852 && ndiv <= 13'h859, 1'b1);
        wrap_up();
    end
endmodule
